// ===== rtl/ufc_frame_config.v
// Functional notes
// - Multiprocessor bit set enables receiver address mode; clear disables it.
// - Mode field: 0 async, 1 sync, 2 infrared, 3 host SPI.
// - Host SPI mode shows mode, order, phase; other modes parity, stop, size.
// - Parity: 0 none, 2 even, 3 odd; 1 reserved.
// - Stop bit 0 gives one stop bit, 1 gives two; receiver ignores it.
// - Size 0..3 give five to eight bits; 6 and 7 nine bits; 4, 5 reserved.
// - Frame control resets to 0x03: async, no parity, one stop, eight bits.
// - SPI order bit 0 sends MSB first, 1 LSB first, both directions.
// - SPI phase bit 0 samples leading edge, 1 trailing edge.
// - Baud divisor is 16 bits over two bytes, resetting to zero.
// - Divisor write reloads the prescaler at once, regardless of frames.
// - Sixteen samples per bit, so matched bit pairs are 32 samples apart.
// - LIN window: 32 plus or minus 6, 5, 7 or 8 samples.
// - Debug-run clear halts and ignores events in debug break; set runs.
// - Infrared event input enabled by 0, disabled by 1.
// - Transmit pulse length is eight-bit read/write, resetting to zero.
// - Pulse 0 gives 3/16 bit, 1..FE that many clocks, FF passes through.
// - Receiver mode 3 selects LIN auto-baud, where the window applies.
//
// Decided for this implementation: the APB interface to the registers.
`include "ufc_defines.vh"

module ufc_frame_config #(
  parameter ADDR_W = 8
) (
  input  wire              clk_in,
  input  wire              rst_in,
  input  wire              psel_in,
  input  wire              penable_in,
  input  wire              pwrite_in,
  input  wire [ADDR_W-1:0] paddr_in,
  input  wire [31:0]       pwdata_in,
  input  wire [3:0]        pstrb_in,
  output wire              pready_out,
  output wire              pslverr_out,
  output wire [31:0]       prdata_out,
  input  wire              dbg_halt_in,
  input  wire              ir_event_in,
  input  wire              tx_bit_in,
  input  wire              bit_start_in,
  input  wire              sample_tick_in,
  output wire              multiproc_addr_enable_out,
  output wire [1:0]        comm_mode_select_out,
  output wire              host_spi_mode_out,
  output wire              infrared_mode_out,
  output wire              parity_enable_out,
  output wire              parity_odd_out,
  output wire              stop_bit_count_out,
  output wire [3:0]        char_width_out,
  output wire              nine_bit_high_first_out,
  output wire              spi_bit_order_out,
  output wire              spi_sample_phase_out,
  output wire [15:0]       baud_div_out,
  output wire              baud_reload_out,
  output wire [1:0]        receiver_speed_select_out,
  output wire              lin_constrained_autobaud_out,
  output wire [5:0]        autobaud_min_out,
  output wire [5:0]        autobaud_max_out,
  output wire              run_enable_out,
  output wire              ir_event_out,
  output wire              ir_tx_out
);

////////////////////////////////////////////////////////////////////////////////

  reg  [7:0]  ctrl_b_r;
  reg  [7:0]  frame_r;
  reg  [7:0]  baud_lo_r;
  reg  [7:0]  baud_hi_r;
  reg  [7:0]  abw_r;
  reg  [7:0]  dbg_r;
  reg  [7:0]  evt_r;
  reg  [7:0]  ir_tx_pulse_len_r;
  reg  [31:0] prdata_r;
  reg         reload_r;
  reg  [1:0]  halt_sync_r;
  reg  [1:0]  evt_sync_r;
  reg         ir_event_r;
  reg  [7:0]  pulse_cnt_r;
  reg  [7:0]  pulse_cnt_nxt;
  reg         ir_tx_r;
  reg         ir_tx_nxt;
  reg  [7:0]  rd_byte;
  reg         hit;
  reg  [5:0]  ab_tol;
  reg  [3:0]  width;

  wire [5:0]  idx;
  wire        aligned;
  wire        setup;
  wire        wr;
  wire [7:0]  wbyte;
  wire [1:0]  comm_mode_select;
  wire        spi;
  wire        run_en;
  wire        coding;
  wire        pulse_step;

////////////////////////////////////////////////////////////////////////////////

  assign idx     = paddr_in[7:2];
  assign aligned = (paddr_in[1:0] == 2'h0);
  assign setup   = psel_in & ~penable_in;
  assign wbyte   = pwdata_in[7:0];

  // Writes land only at the completing edge, from the low byte lane alone.
  assign wr = psel_in & penable_in & pwrite_in & pstrb_in[0] & hit & aligned;

  // Zero wait states: read data is captured in the setup cycle.
  assign pready_out  = 1'b1;
  assign pslverr_out = psel_in & penable_in & ~(hit & aligned);
  assign prdata_out  = prdata_r;

////////////////////////////////////////////////////////////////////////////////

  always @*
  begin
    hit     = 1'b1;
    rd_byte = 8'h00;
    case (idx)
      `UFC_IDX_CTRL_B:
        rd_byte = ctrl_b_r;
      `UFC_IDX_FRAME:
        rd_byte = spi ? (frame_r & `UFC_MASK_SPI_VIEW) : frame_r;
      `UFC_IDX_BAUD_LO:
        rd_byte = baud_lo_r;
      `UFC_IDX_BAUD_HI:
        rd_byte = baud_hi_r;
      `UFC_IDX_ABW:
        rd_byte = abw_r;
      `UFC_IDX_DBG:
        rd_byte = dbg_r;
      `UFC_IDX_EVT:
        rd_byte = evt_r;
      `UFC_IDX_IR_TX_PULSE_LEN:
        rd_byte = ir_tx_pulse_len_r;
      default:
        hit = 1'b0;
    endcase
  end

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      prdata_r <= 32'h00000000;
    end
    else if (setup)
    begin
      prdata_r <= {24'h000000, rd_byte};
    end
  end

////////////////////////////////////////////////////////////////////////////////

  // Register file; every field keeps reserved codes as written.
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      ctrl_b_r  <= `UFC_RST_CTRL_B;
      frame_r   <= `UFC_RST_FRAME;
      baud_lo_r <= `UFC_RST_BYTE;
      baud_hi_r <= `UFC_RST_BYTE;
      abw_r     <= `UFC_RST_BYTE;
      dbg_r     <= `UFC_RST_BYTE;
      evt_r     <= `UFC_RST_BYTE;
      ir_tx_pulse_len_r    <= `UFC_RST_BYTE;
      reload_r  <= 1'b0;
    end
    else
    begin
      reload_r <= 1'b0;
      if (wr)
      begin
        case (idx)
          `UFC_IDX_CTRL_B:
            ctrl_b_r <= wbyte & `UFC_MASK_CTRL_B;
          `UFC_IDX_FRAME:
          begin
            if (wbyte[`UFC_COMM_MODE_SELECT_HI:`UFC_COMM_MODE_SELECT_LO] == `UFC_CM_SPI)
              frame_r <= wbyte & `UFC_MASK_SPI_VIEW;
            else
              frame_r <= wbyte;
          end
          `UFC_IDX_BAUD_LO:
          begin
            baud_lo_r <= wbyte;
            reload_r  <= 1'b1;
          end
          `UFC_IDX_BAUD_HI:
          begin
            baud_hi_r <= wbyte;
            reload_r  <= 1'b1;
          end
          `UFC_IDX_ABW:
            abw_r <= wbyte & `UFC_MASK_ABW;
          `UFC_IDX_DBG:
            dbg_r <= wbyte & `UFC_MASK_BIT0;
          `UFC_IDX_EVT:
            evt_r <= wbyte & `UFC_MASK_BIT0;
          `UFC_IDX_IR_TX_PULSE_LEN:
            ir_tx_pulse_len_r <= wbyte;
          default:
            reload_r <= 1'b0;
        endcase
      end
    end
  end

////////////////////////////////////////////////////////////////////////////////

  assign comm_mode_select                = frame_r[`UFC_COMM_MODE_SELECT_HI:`UFC_COMM_MODE_SELECT_LO];
  assign spi                  = (comm_mode_select == `UFC_CM_SPI);
  assign comm_mode_select_out = comm_mode_select;
  assign host_spi_mode_out    = spi;
  assign infrared_mode_out    = (comm_mode_select == `UFC_CM_IR);

  assign multiproc_addr_enable_out = ctrl_b_r[`UFC_MULTIPROC_ADDR_ENABLE_BIT];

  assign parity_enable_out =
    ~spi & (frame_r[`UFC_PARITY_SELECT_HI:`UFC_PARITY_SELECT_LO] == `UFC_PAR_EVEN
          | frame_r[`UFC_PARITY_SELECT_HI:`UFC_PARITY_SELECT_LO] == `UFC_PAR_ODD);
  assign parity_odd_out =
    ~spi & (frame_r[`UFC_PARITY_SELECT_HI:`UFC_PARITY_SELECT_LO] == `UFC_PAR_ODD);

  assign stop_bit_count_out = ~spi & frame_r[`UFC_STOP_BIT_COUNT_BIT];

  always @*
  begin
    case (frame_r[`UFC_CHSZ_HI:`UFC_CHSZ_LO])
      3'h0, 3'h1, 3'h2, 3'h3:
        width = `UFC_CS_BASE + {2'h0, frame_r[1:0]};
      `UFC_CS_9L, `UFC_CS_9H:
        width = `UFC_CS_NINE;
      default:
        width = `UFC_CS_EIGHT;
    endcase
  end

  // Reserved sizes fall back to eight bits; no user should count on it.
  assign char_width_out = spi ? `UFC_CS_EIGHT : width;
  assign nine_bit_high_first_out =
    ~spi & (frame_r[`UFC_CHSZ_HI:`UFC_CHSZ_LO] == `UFC_CS_9H);

  assign spi_bit_order_out = spi & frame_r[`UFC_ORDER_BIT];

  assign spi_sample_phase_out = spi & frame_r[`UFC_PHASE_BIT];

  assign baud_div_out    = {baud_hi_r, baud_lo_r};
  assign baud_reload_out = reload_r;

////////////////////////////////////////////////////////////////////////////////

  assign receiver_speed_select_out = ctrl_b_r[`UFC_RECEIVER_SPEED_SELECT_HI:`UFC_RECEIVER_SPEED_SELECT_LO];

  assign lin_constrained_autobaud_out =
    (ctrl_b_r[`UFC_RECEIVER_SPEED_SELECT_HI:`UFC_RECEIVER_SPEED_SELECT_LO] == `UFC_RXM_LIN_CONSTRAINED_AUTOBAUD);

  always @*
  begin
    case (abw_r[`UFC_ABW_HI:`UFC_ABW_LO])
      2'h0:
        ab_tol = `UFC_AB_TOL0;
      2'h1:
        ab_tol = `UFC_AB_TOL1;
      2'h2:
        ab_tol = `UFC_AB_TOL2;
      default:
        ab_tol = `UFC_AB_TOL3;
    endcase
  end

  assign autobaud_min_out = `UFC_AB_NOMINAL - ab_tol;
  assign autobaud_max_out = `UFC_AB_NOMINAL + ab_tol;

////////////////////////////////////////////////////////////////////////////////

  // Both pins are asynchronous to clk_in, so each gets two flops first.
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      halt_sync_r <= 2'h0;
      evt_sync_r  <= 2'h0;
    end
    else
    begin
      halt_sync_r <= {halt_sync_r[0], dbg_halt_in};
      evt_sync_r  <= {evt_sync_r[0], ir_event_in};
    end
  end

  assign run_en         = dbg_r[`UFC_ONEBIT] | ~halt_sync_r[1];
  assign run_enable_out = run_en;

  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
      ir_event_r <= 1'b0;
    else
      ir_event_r <= evt_sync_r[1] & ~evt_r[`UFC_ONEBIT] & run_en;
  end

  assign ir_event_out = ir_event_r;

////////////////////////////////////////////////////////////////////////////////

  // A zero bit is sent as a low pulse on an otherwise high line.
  assign coding     = infrared_mode_out & (ir_tx_pulse_len_r != `UFC_PL_PASS);
  assign pulse_step = (ir_tx_pulse_len_r == `UFC_PL_SIXTEENTHS) ? sample_tick_in : 1'b1;

  always @*
  begin
    pulse_cnt_nxt = pulse_cnt_r;
    ir_tx_nxt     = tx_bit_in;
    if (coding)
    begin
      ir_tx_nxt = 1'b1;
      if (bit_start_in & ~tx_bit_in)
      begin
        if (ir_tx_pulse_len_r == `UFC_PL_SIXTEENTHS)
          pulse_cnt_nxt = `UFC_PL_3_16;
        else
          pulse_cnt_nxt = ir_tx_pulse_len_r;
        ir_tx_nxt = 1'b0;
      end
      else if (pulse_cnt_r != 8'h00)
      begin
        ir_tx_nxt = 1'b0;
        if (pulse_step)
        begin
          pulse_cnt_nxt = pulse_cnt_r - `UFC_PL_ONE;
          if (pulse_cnt_r == `UFC_PL_ONE)
            ir_tx_nxt = 1'b1;
        end
      end
    end
    else
    begin
      pulse_cnt_nxt = 8'h00;
    end
  end

  // The shaper freezes while halted so a pulse resumes where it stopped.
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in)
    begin
      pulse_cnt_r <= 8'h00;
      ir_tx_r     <= 1'b1;
    end
    else if (run_en)
    begin
      pulse_cnt_r <= pulse_cnt_nxt;
      ir_tx_r     <= ir_tx_nxt;
    end
  end

  assign ir_tx_out = ir_tx_r;

endmodule

// ===== rtl/ufc_defines.vh
`ifndef UFC_DEFINES_VH
`define UFC_DEFINES_VH

// Register indices; byte address is four times the index.
`define UFC_IDX_CTRL_B     6'h06
`define UFC_IDX_FRAME      6'h07
`define UFC_IDX_BAUD_LO    6'h08
`define UFC_IDX_BAUD_HI    6'h09
`define UFC_IDX_ABW        6'h0A
`define UFC_IDX_DBG        6'h0B
`define UFC_IDX_EVT        6'h0C
`define UFC_IDX_IR_TX_PULSE_LEN       6'h0D

// Reset values.
`define UFC_RST_CTRL_B     8'h00
`define UFC_RST_FRAME      8'h03
`define UFC_RST_BYTE       8'h00

// Writable masks.
`define UFC_MASK_CTRL_B    8'hDF
`define UFC_MASK_SPI_VIEW  8'hC6
`define UFC_MASK_ABW       8'hC0
`define UFC_MASK_BIT0      8'h01

// Field positions.
`define UFC_COMM_MODE_SELECT_HI       7
`define UFC_COMM_MODE_SELECT_LO       6
`define UFC_PARITY_SELECT_HI       5
`define UFC_PARITY_SELECT_LO       4
`define UFC_STOP_BIT_COUNT_BIT     3
`define UFC_CHSZ_HI        2
`define UFC_CHSZ_LO        0
`define UFC_ORDER_BIT      2
`define UFC_PHASE_BIT      1
`define UFC_MULTIPROC_ADDR_ENABLE_BIT       0
`define UFC_RECEIVER_SPEED_SELECT_HI      2
`define UFC_RECEIVER_SPEED_SELECT_LO      1
`define UFC_ABW_HI         7
`define UFC_ABW_LO         6
`define UFC_ONEBIT         0

// Communication modes.
`define UFC_CM_ASYNC       2'h0
`define UFC_CM_SYNC        2'h1
`define UFC_CM_IR          2'h2
`define UFC_CM_SPI         2'h3

// Parity, receiver and size encodings.
`define UFC_PAR_EVEN       2'h2
`define UFC_PAR_ODD        2'h3
`define UFC_RXM_LIN_CONSTRAINED_AUTOBAUD    2'h3
`define UFC_CS_9L          3'h6
`define UFC_CS_9H          3'h7
`define UFC_CS_BASE        4'h5
`define UFC_CS_NINE        4'h9
`define UFC_CS_EIGHT       4'h8

// Auto-baud window: nominal count and tolerances.
`define UFC_AB_NOMINAL     6'h20
`define UFC_AB_TOL0        6'h06
`define UFC_AB_TOL1        6'h05
`define UFC_AB_TOL2        6'h07
`define UFC_AB_TOL3        6'h08

// Infrared pulse length codes.
`define UFC_PL_SIXTEENTHS  8'h00
`define UFC_PL_PASS        8'hFF
`define UFC_PL_3_16        8'h03
`define UFC_PL_ONE         8'h01

`endif

// ===== testbench/ufc_frame_config_chk.sv
module ufc_frame_config_chk #(
  parameter ADDR_W = 8
) (
  input wire logic              clk_in,
  input wire logic              rst_in,
  input wire logic              psel_in,
  input wire logic              penable_in,
  input wire logic              pwrite_in,
  input wire logic [ADDR_W-1:0] paddr_in,
  input wire logic [31:0]       pwdata_in,
  input wire logic [3:0]        pstrb_in,
  input wire logic [1:0]        comm_mode_select_out,
  input wire logic              host_spi_mode_out,
  input wire logic              infrared_mode_out,
  input wire logic              parity_enable_out,
  input wire logic              stop_bit_count_out,
  input wire logic [3:0]        char_width_out,
  input wire logic              nine_bit_high_first_out,
  input wire logic [15:0]       baud_div_out,
  input wire logic              baud_reload_out,
  input wire logic [5:0]        autobaud_min_out,
  input wire logic [5:0]        autobaud_max_out,
  input wire logic              run_enable_out,
  input wire logic              tx_bit_in,
  input wire logic              ir_tx_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_in); endclocking
  default disable iff (rst_in);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_lo_wr;
    psel_in && penable_in && pwrite_in && pstrb_in[0] && paddr_in == 'h20;
  endsequence
  property p_rst;
    $fell(rst_in) |-> comm_mode_select_out == 2'h0 && char_width_out == 4'h8
      && !parity_enable_out && !stop_bit_count_out;
  endproperty
  a_rst: assert property (p_rst) else $error("frame reset value wrong");
  property p_spi;
    host_spi_mode_out |-> char_width_out == 4'h8 && !parity_enable_out
      && !stop_bit_count_out && !nine_bit_high_first_out;
  endproperty
  a_spi: assert property (p_spi) else $error("spi view leaks frame fields");
  property p_mode;
    host_spi_mode_out == (comm_mode_select_out == 2'h3)
      && infrared_mode_out == (comm_mode_select_out == 2'h2);
  endproperty
  a_mode: assert property (p_mode) else $error("mode decode wrong");
  property p_rel;
    s_lo_wr |=> baud_reload_out;
  endproperty
  a_rel: assert property (p_rel) else $error("no prescaler reload");
  property p_lo;
    s_lo_wr |=> baud_div_out[7:0] == $past(pwdata_in[7:0]);
  endproperty
  a_lo: assert property (p_lo) else $error("baud low byte not stored");
  property p_ab;
    autobaud_min_out + autobaud_max_out == 7'd64
      && (autobaud_max_out - autobaud_min_out) inside {6'd10, 6'd12, 6'd14, 6'd16};
  endproperty
  a_ab: assert property (p_ab) else $error("autobaud window wrong");
  property p_halt;
    !run_enable_out |=> $stable(ir_tx_out);
  endproperty
  a_halt: assert property (p_halt) else $error("shaper moved while halted");
  property p_pass;
    !infrared_mode_out && run_enable_out |=> ir_tx_out == $past(tx_bit_in);
  endproperty
  a_pass: assert property (p_pass) else $error("pass through broken");
endmodule

bind ufc_frame_config ufc_frame_config_chk #(.ADDR_W(ADDR_W)) u_chk (.clk_in, .rst_in,
  .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .pstrb_in,
  .comm_mode_select_out, .host_spi_mode_out, .infrared_mode_out, .parity_enable_out,
  .stop_bit_count_out, .char_width_out, .nine_bit_high_first_out, .baud_div_out,
  .baud_reload_out, .autobaud_min_out, .autobaud_max_out, .run_enable_out,
  .tx_bit_in, .ir_tx_out);

// ===== testbench/ufc_line_model.sv
module ufc_line_model #(
  parameter TICK = 4
) (
  input  wire logic clk_in,
  input  wire logic rst_in,
  input  wire logic en_in,
  output logic      tick_out,
  output logic      bit_start_out,
  output logic      tx_bit_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] c_r;
  logic [3:0] t_r;
  // Sixteen ticks per bit.
  // The line idles high so a stopped link never looks like a start bit.
  always @(posedge clk_in or posedge rst_in)
  begin
    if (rst_in || !en_in)
    begin
      c_r <= 8'h00;
      t_r <= 4'h0;
      tick_out <= 1'b0;
      bit_start_out <= 1'b0;
      tx_bit_out <= 1'b1;
    end
    else
    begin
      tick_out <= c_r == 8'h00;
      bit_start_out <= c_r == 8'h00 && t_r == 4'h0;
      c_r <= (c_r == TICK - 1) ? 8'h00 : c_r + 8'h01;
      if (c_r == 8'h00)
        t_r <= t_r + 4'h1;
      if (c_r == 8'h00 && t_r == 4'h0)
        tx_bit_out <= ~tx_bit_out;
    end
  end
endmodule

// ===== testbench/tb_usart_frame_and_mode_config.sv
module tb_usart_frame_and_mode_config;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {logic [7:0] a; logic [7:0] w; logic [7:0] r; logic [8:0] p;} ufc_row_t;
  logic clk_in = 0, rst_in = 1, psel_in = 0, penable_in = 0, pwrite_in = 0;
  logic dbg_halt_in = 0, ir_event_in = 0, line_en = 0;
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, rd;
  logic [3:0] pstrb_in = 4'hF;
  logic [7:0] v;
  logic err;
  wire pready_out, pslverr_out, multiproc_addr_enable_out, host_spi_mode_out;
  wire infrared_mode_out, parity_enable_out, parity_odd_out, stop_bit_count_out;
  wire nine_bit_high_first_out, spi_bit_order_out, spi_sample_phase_out, baud_reload_out;
  wire lin_constrained_autobaud_out, run_enable_out, ir_event_out, ir_tx_out;
  wire tx_bit_in, bit_start_in, sample_tick_in;
  wire [31:0] prdata_out;
  wire [1:0] comm_mode_select_out, receiver_speed_select_out;
  wire [3:0] char_width_out;
  wire [15:0] baud_div_out;
  wire [5:0] autobaud_min_out, autobaud_max_out, tol;
  wire [8:0] probe = {comm_mode_select_out, parity_enable_out, parity_odd_out,
                      stop_bit_count_out, char_width_out};
  integer n_fail = 0, cmp_count = 0, i, n;
  ufc_row_t rows [0:15];
  ufc_frame_config uut (.*);
  ufc_line_model #(.TICK(4)) u_line (.clk_in, .rst_in, .en_in(line_en),
    .tick_out(sample_tick_in), .bit_start_out(bit_start_in), .tx_bit_out(tx_bit_in));
  always #5 clk_in = ~clk_in;
  ////////////////////////////////////////////////////////////////////////////
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e)
    begin
      n_fail++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask
  task results;
    $display("checks %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Zero wait states are expected, but the wait is still bounded.
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    integer k;
    psel_in <= 1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= {24'h0, d};
    @(posedge clk_in);
    penable_in <= 1;
    k = 0;
    @(posedge clk_in);
    while (pready_out !== 1'b1 && k < 20)
    begin
      k++;
      @(posedge clk_in);
    end
    if (k == 20)
    begin
      n_fail++;
      results();
    end
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 0;
    penable_in <= 0;
    @(posedge clk_in);
  endtask
  assign tol = 6'h20 - autobaud_min_out;
  initial
  begin
    repeat (100000) @(posedge clk_in);
    n_fail++;
    results();
  end
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rows = '{'{8'h18, 8'hFF, 8'hDF, 9'h008}, '{8'h20, 8'hA5, 8'hA5, 9'h008},
             '{8'h24, 8'h5A, 8'h5A, 9'h008}, '{8'h28, 8'hFF, 8'hC0, 9'h008},
             '{8'h2C, 8'hFF, 8'h01, 9'h008}, '{8'h30, 8'hFF, 8'h01, 9'h008},
             '{8'h34, 8'h7E, 8'h7E, 9'h008}, '{8'h3C, 8'hFF, 8'h00, 9'h008},
             '{8'h1C, 8'h5C, 8'h5C, 9'h098}, '{8'h1C, 8'hA6, 8'hA6, 9'h149},
             '{8'h1C, 8'h3F, 8'h3F, 9'h079}, '{8'h1C, 8'h00, 8'h00, 9'h005},
             '{8'h1C, 8'h01, 8'h01, 9'h006}, '{8'h1C, 8'h02, 8'h02, 9'h007},
             '{8'h1C, 8'h05, 8'h05, 9'h008}, '{8'h1C, 8'hFF, 8'hC6, 9'h188}};
    repeat (12) @(posedge clk_in);
    rst_in <= 0;
    @(posedge clk_in);
    for (i = 0; i < 8; i++)
    begin
      apb(0, 8'h18 + 8'(4 * i), 8'h00);
      chk("reset", (i == 1) ? 3 : 0, rd);
    end
    for (i = 0; i < 16; i++)
    begin
      apb(1, rows[i].a, rows[i].w);
      apb(0, rows[i].a, 8'h00);
      chk("rdata", {24'h0, rows[i].r}, rd);
      chk("slverr", rows[i].a == 8'h3C, err);
      chk("fields", rows[i].p, probe);
      chk("ninehi", i == 10, nine_bit_high_first_out);
    end
    chk("multiproc_addr_enable", 1, multiproc_addr_enable_out);
    chk("receiver_speed_select", 3, receiver_speed_select_out);
    chk("lin_constrained_autobaud", 1, lin_constrained_autobaud_out);
    for (i = 0; i < 4; i++)
    begin
      apb(1, 8'h28, 8'(i << 6));
      chk("abtol", (i == 0) ? 6 : (i == 1) ? 5 : (i == 2) ? 7 : 8, tol);
      chk("abmax", 6'h20 + tol, autobaud_max_out);
    end
    // Order is only changed while the line model is stopped.
    for (i = 0; i < 2; i++)
    begin
      apb(1, 8'h1C, i ? 8'hC2 : 8'hC4);
      chk("order", !i, spi_bit_order_out);
      chk("phase", i, spi_sample_phase_out);
    end
    apb(1, 8'h20, 8'h33);
    chk("baud", 16'h5A33, baud_div_out);
    apb(1, 8'h2C, 8'h00);
    apb(1, 8'h30, 8'h00);
    dbg_halt_in <= 1;
    ir_event_in <= 1;
    repeat (6) @(posedge clk_in);
    chk("run", 0, run_enable_out);
    chk("event", 0, ir_event_out);
    dbg_halt_in <= 0;
    repeat (6) @(posedge clk_in);
    chk("event", 1, ir_event_out);
    apb(1, 8'h30, 8'h01);
    repeat (3) @(posedge clk_in);
    chk("event", 0, ir_event_out);
    apb(1, 8'h2C, 8'h01);
    dbg_halt_in <= 1;
    repeat (6) @(posedge clk_in);
    chk("run", 1, run_enable_out);
    dbg_halt_in <= 0;
    apb(1, 8'h1C, 8'h83);
    // Two full bit pairs are counted so a pulse cut at the window edge still adds up.
    for (i = 0; i < 2; i++)
    begin
      v = i ? 8'h00 : 8'h04;
      apb(1, 8'h34, v);
      line_en <= 1;
      repeat (200) @(posedge clk_in);
      n = 0;
      repeat (256)
      begin
        @(posedge clk_in);
        if (ir_tx_out === 1'b0)
          n++;
      end
      line_en <= 0;
      @(posedge clk_in);
      chk("pulse", i ? 24 : 8, n);
    end
    // A reset in mid-run must bring back the documented defaults.
    rst_in <= 1;
    repeat (2) @(posedge clk_in);
    rst_in <= 0;
    @(posedge clk_in);
    apb(0, 8'h1C, 8'h00);
    chk("rst_frame", 32'h03, rd);
    apb(0, 8'h24, 8'h00);
    chk("rst_baud", 32'h00, rd);
    // A write with the low byte strobe clear must leave the register alone.
    pstrb_in <= 4'hE;
    apb(1, 8'h34, 8'h55);
    pstrb_in <= 4'hF;
    apb(0, 8'h34, 8'h00);
    chk("strobe", 32'h00, rd);
    results();
  end
endmodule
